// >>> logic/spio_pkg.sv
// Package with register map and layout constants for the shared port block.
package spio_pkg;

  // ****************************************************************
  // Register map (byte addresses on the 32-bit bus)
  // ****************************************************************
  localparam logic [3:0] ADDR_DIR    = 4'h0;
  localparam logic [3:0] ADDR_PINLVL = 4'h4;
  localparam logic [3:0] ADDR_LATCH  = 4'h8;
  localparam logic [3:0] ADDR_ANCFG  = 4'hc;

  // ****************************************************************
  // Port layout and reset values
  // ****************************************************************
  localparam int          PORT_WIDTH   = 16;
  localparam logic [15:0] IMPL_MASK    = 16'h003f;
  localparam logic [15:0] ANALOG_MASK  = 16'h003f;
  localparam logic [15:0] LATCH_RESET  = 16'h0000;
  localparam logic [15:0] ANCFG_RESET  = 16'h0000;
  localparam int          SYNC_STAGES  = 2;

endpackage

// >>> logic/spio_port.sv
// Shared parallel I/O port with Wishbone register access.
//
// Implementation choices: the address map and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none

module spio_port
  import spio_pkg::*;
#(
  parameter logic [15:0] IMPL  = IMPL_MASK,
  parameter logic [15:0] ANCAP = ANALOG_MASK
) (
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave.
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Peripheral side per pin.
  input  wire logic [15:0] periph_en_i,
  input  wire logic [15:0] periph_drive_i,
  input  wire logic [15:0] periph_dat_i,
  // Pads.
  input  wire logic [15:0] pad_in_i,
  output logic      [15:0] pad_out_o,
  output logic      [15:0] pad_oe_n_o,
  // Converter side.
  output logic      [15:0] adc_sel_o,
  output logic      [15:0] adc_dig_o
);

  // ****************************************************************
  // Registers and synchronizer
  // ****************************************************************
  logic [15:0] dir_ff;
  logic [15:0] lat_ff;
  logic [15:0] ancfg_ff;
  logic [15:0] sync1_ff;
  logic [15:0] sync2_ff;
  logic        ack_ff;
  logic [31:0] rdat_ff;
  logic [15:0] out_ff;
  logic [15:0] oen_ff;
  logic [15:0] asel_ff;
  logic [15:0] adig_ff;

  function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                          input logic [31:0] wd,
                                          input logic [3:0]  sel);
    merge16 = old_v;
    if (sel[0]) merge16[7:0]  = wd[7:0];
    if (sel[1]) merge16[15:8] = wd[15:8];
  endfunction

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  wire req      = wb_cyc_i & wb_stb_i & ~ack_ff;
  wire wr       = req & wb_we_i;
  wire hit_dir  = (wb_adr_i == ADDR_DIR);
  wire hit_pin  = (wb_adr_i == ADDR_PINLVL);
  wire hit_lat  = (wb_adr_i == ADDR_LATCH);
  wire hit_an   = (wb_adr_i == ADDR_ANCFG);
  wire [15:0] an_pins  = ancfg_ff & ANCAP & IMPL;
  wire [15:0] pin_read = sync2_ff & ~an_pins & IMPL;
  wire [15:0] rd_val;
  assign rd_val = hit_dir ? (dir_ff & IMPL) :
                  hit_pin ? pin_read :
                  hit_lat ? (lat_ff & IMPL) :
                  hit_an  ? an_pins : 16'h0000;

  // ****************************************************************
  // Pad multiplexers
  // ****************************************************************
  wire [15:0] per_own = periph_en_i & periph_drive_i;
  wire [15:0] port_oe = ~dir_ff & IMPL;
  wire [15:0] nxt_out = ((per_own & periph_dat_i) |
                        (~per_own & lat_ff)) & IMPL;
  wire [15:0] nxt_oen = ~(((per_own) | port_oe) & IMPL);

  // Two flops keep a metastable pad level away from the read multiplexer.
  // Only the second stage is read by any logic past the synchronizer.
  // A pin-level read therefore shows a pad change three cycles later.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_ff <= 16'h0000;
      sync2_ff <= 16'h0000;
    end else begin
      sync1_ff <= pad_in_i;
      sync2_ff <= sync1_ff;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dir_ff   <= 16'hffff & IMPL;
      lat_ff   <= LATCH_RESET;
      ancfg_ff <= ANCFG_RESET;
    end else if (wr) begin
      if (hit_dir) dir_ff <= merge16(dir_ff, wb_dat_i, wb_sel_i) & IMPL;
      if (hit_lat | hit_pin)
        lat_ff <= merge16(lat_ff, wb_dat_i, wb_sel_i) & IMPL;
      if (hit_an) ancfg_ff <= merge16(ancfg_ff, wb_dat_i, wb_sel_i) & ANCAP;
    end
  end

  // Every request is answered one cycle after it is taken.
  // The ack term in the request keeps a held strobe from an answer in the cycle right after ack.
  // Read data stands only with ack, so the bus sees zero otherwise.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff  <= 1'b0;
      rdat_ff <= 32'h0000_0000;
    end else begin
      ack_ff  <= req;
      rdat_ff <= req ? {16'h0000, rd_val} : 32'h0000_0000;
    end
  end

  // Pad and converter outputs are registered so that no decode glitch
  // reaches a pad cell; they follow their sources one cycle later.
  // Pads leave reset released, so only a peripheral that asserts periph_en_i and periph_drive_i drives a pin before software acts.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_ff  <= 16'h0000;
      oen_ff  <= 16'hffff;
      asel_ff <= 16'h0000;
      adig_ff <= 16'h0000;
    end else begin
      out_ff  <= nxt_out;
      oen_ff  <= nxt_oen;
      asel_ff <= an_pins;
      adig_ff <= an_pins & port_oe & nxt_out;
    end
  end

  assign wb_ack_o   = ack_ff;
  assign wb_dat_o   = rdat_ff;
  assign pad_out_o  = out_ff;
  assign pad_oe_n_o = oen_ff;
  assign adc_sel_o  = asel_ff;
  assign adc_dig_o  = adig_ff;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  reset_dir_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(rst_i) |-> dir_ff == IMPL)
    else $error("direction not all inputs after reset");
  periph_own_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (periph_en_i[0] & periph_drive_i[0]) |=> !pad_oe_n_o[0] &&
      pad_out_o[0] == $past(periph_dat_i[0]))
    else $error("peripheral lost pad ownership");
  port_own_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!periph_drive_i[1] && !dir_ff[1]) |=> !pad_oe_n_o[1] &&
      pad_out_o[1] == $past(lat_ff[1]))
    else $error("port did not drive idle pin");
  input_dir_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!periph_drive_i[2] && dir_ff[2]) |=> pad_oe_n_o[2])
    else $error("input pin is driven");
  unimpl_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (dir_ff & ~IMPL) == 16'h0000 && (lat_ff & ~IMPL) == 16'h0000
      && (pad_oe_n_o & ~IMPL) == (~IMPL))
    else $error("unimplemented bit active");
  pin_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && hit_pin && wb_sel_i[1:0] == 2'b11) |=>
      lat_ff == ($past(wb_dat_i[15:0]) & IMPL))
    else $error("pin write missed latch");
  analog_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && !wb_we_i && hit_pin) |=> (wb_dat_o[15:0] & an_pins) == 16'h0
      || $past(ancfg_ff) != ancfg_ff)
    else $error("analog pin read non-zero");
  sync_path_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ##2 sync2_ff == $past(pad_in_i, 2))
    else $error("synchronizer depth wrong");
  ack_once_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");
  digital_no_an_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!ancfg_ff[3]) |=> !adc_sel_o[3])
    else $error("digital pin routed to converter");

  // ****************************************************************
  // Bus handshake assertions
  // ****************************************************************
  // These guard the single-cycle answer that the bus master relies on.

  ack_resp_a: assert property (@(posedge clk_i) disable iff (rst_i)
    req |=> wb_ack_o)
    else $error("request not answered in one cycle");

  idle_no_ack_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");

  dat_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data outside ack");

  upper_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_dat_o[31:16] == 16'h0000)
    else $error("upper read bits not zero");

  unmapped_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && !wb_we_i && !hit_dir && !hit_pin && !hit_lat && !hit_an)
      |=> wb_dat_o == 32'h0000_0000)
    else $error("unmapped read not zero");

  // ****************************************************************
  // Register and pad assertions
  // ****************************************************************
  // Register checks use full 16-bit writes or a single low byte.

  dir_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && !wb_we_i && hit_dir) |=> wb_dat_o[15:0] == $past(dir_ff))
    else $error("direction read wrong");

  lat_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && !wb_we_i && hit_lat) |=> wb_dat_o[15:0] == $past(lat_ff))
    else $error("latch read wrong");

  lat_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && hit_lat && wb_sel_i[1:0] == 2'b11) |=>
      lat_ff == ($past(wb_dat_i[15:0]) & IMPL))
    else $error("latch write lost");

  dir_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && hit_dir && wb_sel_i[1:0] == 2'b11) |=>
      dir_ff == ($past(wb_dat_i[15:0]) & IMPL))
    else $error("direction write lost");

  byte_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && hit_lat && wb_sel_i[1:0] == 2'b01) |=>
      lat_ff[15:8] == $past(lat_ff[15:8]))
    else $error("unselected latch byte changed");

  no_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !wr |=> lat_ff == $past(lat_ff))
    else $error("latch changed without write");

  unimpl_pad_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (pad_out_o & ~IMPL) == 16'h0000)
    else $error("unimplemented pad driven high");

  unimpl_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wb_dat_o[15:0] & ~IMPL & ~ANCAP) == 16'h0000)
    else $error("unimplemented bit read non-zero");

  oe_reset_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(rst_i) |-> pad_oe_n_o == 16'hffff)
    else $error("pad driven right after reset");

  port_data_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!periph_en_i[4] && !dir_ff[4]) |=>
      !pad_oe_n_o[4] && pad_out_o[4] == $past(lat_ff[4]))
    else $error("port lost idle pad");

  // ****************************************************************
  // Converter assertions
  // ****************************************************************
  // The converter sees only pins that software marked analog.

  an_cfg_mask_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (ancfg_ff & ~ANCAP) == 16'h0000)
    else $error("analog setting on incapable pin");

  adc_mask_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (adc_sel_o & ~(ANCAP & IMPL)) == 16'h0000)
    else $error("incapable pin routed to converter");

  adc_dig_sel_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (adc_dig_o & ~adc_sel_o) == 16'h0000)
    else $error("digital level on non-analog pin");

  adc_in_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (ancfg_ff[0] && dir_ff[0]) |=> !adc_dig_o[0])
    else $error("input pin shows driven level");

  adc_follow_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ancfg_ff[1] |=> adc_sel_o[1])
    else $error("analog pin not routed");

endmodule

`default_nettype wire

// >>> tb/spio_port_tb.sv
// Self-checking testbench for the shared parallel I/O port.
`timescale 1ns/1ps
`default_nettype none
module spio_port_tb import spio_pkg::*; ;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [3:0]  wb_adr_i = 4'h0;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic [15:0] periph_en_i = 16'h0;
  logic [15:0] periph_drive_i = 16'h0;
  logic [15:0] periph_dat_i = 16'h0;
  logic [15:0] pad_in_i = 16'h0;
  logic [15:0] pad_out_o, pad_oe_n_o, adc_sel_o, adc_dig_o;
  logic [31:0] rd;
  int          num_errors = 0;
  int          n_checks = 0;
  always #2.5 clk_i = ~clk_i;
  spio_port DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .periph_en_i(periph_en_i),
    .periph_drive_i(periph_drive_i), .periph_dat_i(periph_dat_i),
    .pad_in_i(pad_in_i), .pad_out_o(pad_out_o), .pad_oe_n_o(pad_oe_n_o),
    .adc_sel_o(adc_sel_o), .adc_dig_o(adc_dig_o));
  // ****************************************************************
  // Bus cycles and comparisons
  // ****************************************************************
  task automatic test_done();
    $display("checks %0d, mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // One classic cycle; holds the request until ack is sampled high.
  task automatic bus(input logic we, input logic [3:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1; wb_stb_i <= 1'b1; wb_we_i <= we;
    wb_adr_i <= a; wb_sel_i <= 4'h3; wb_dat_i <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) begin
      num_errors++;
      test_done();
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0; wb_stb_i <= 1'b0; wb_we_i <= 1'b0;
  endtask
  task automatic chk_reg(input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    n_checks++;
    if (rd !== e) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, rd, e);
    end
  endtask
  // Pad values are looked at once the registered outputs have settled.
  task automatic chk_pad(input logic [15:0] g, input logic [15:0] e);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic settle();
    repeat (4) @(posedge clk_i);
    #1;
  endtask
  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    settle();
    chk_pad(pad_oe_n_o, 16'hffff);
    chk_reg(ADDR_DIR, 32'h0000003f);
    chk_reg(ADDR_LATCH, {16'h0, LATCH_RESET});
    bus(1'b1, 4'h2, 32'h0000ffff);
    chk_reg(4'h2, 32'h0);
    $display("test reset done");
    bus(1'b1, ADDR_LATCH, 32'h0000ffff);
    chk_reg(ADDR_LATCH, {16'h0, IMPL_MASK});
    bus(1'b1, ADDR_DIR, 32'h0);
    chk_reg(ADDR_DIR, 32'h0);
    settle();
    chk_pad(pad_oe_n_o, ~IMPL_MASK);
    chk_pad(pad_out_o, IMPL_MASK);
    bus(1'b1, ADDR_PINLVL, 32'h00000015);
    chk_reg(ADDR_LATCH, 32'h00000015);
    $display("test latch done");
    periph_en_i <= 16'h0003; periph_drive_i <= 16'h0001;
    periph_dat_i <= 16'h0002; pad_in_i <= 16'hff2a;
    settle();
    chk_pad(pad_out_o, 16'h0014);
    chk_pad(pad_oe_n_o, ~IMPL_MASK);
    chk_reg(ADDR_PINLVL, 32'h0000002a);
    $display("test peripheral done");
    periph_en_i <= 16'h0; periph_drive_i <= 16'h0;
    bus(1'b1, ADDR_DIR, 32'h0000003f);
    bus(1'b1, ADDR_ANCFG, 32'h0000ffff);
    chk_reg(ADDR_ANCFG, {16'h0, ANALOG_MASK});
    chk_reg(ADDR_PINLVL, 32'h0);
    bus(1'b1, ADDR_ANCFG, 32'h00000003);
    bus(1'b1, ADDR_DIR, 32'h0000003c);
    settle();
    chk_pad(adc_sel_o, 16'h0003);
    chk_pad(adc_dig_o & 16'h0003, 16'h0001);
    chk_reg(ADDR_PINLVL, 32'h00000028);
    $display("test analog done");
    test_done();
  end
endmodule
`default_nettype wire
